/* File: hw/dir_pkg.sv */
// constants for the die identity readout block
package dir_pkg;
	// register indices, byte address is four times the index
	localparam logic [7:0] FUSE_UP_IDX = 8'h2f;
	localparam logic [7:0] FUSE_LO_IDX = 8'h30;
	localparam logic [7:0] STATUS_IDX = 8'h3a;
	localparam logic [7:0] WDOG_IDX = 8'h3b;
	localparam logic [7:0] CRC_IDX = 8'h3c;
	localparam logic [7:0] PAGE_IDX = 8'h3e;
	// page select values
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] PAGE_FUSE = 8'h02;
	// field positions of the identity fuses
	localparam int COL_LSB = 2;
	localparam int ROWU_LSB = 0;
	localparam int ROWL_LSB = 4;
	localparam int WAFER_LSB = 0;
	// status register bit positions
	localparam int ST_ROLE_BIT = 0;
	localparam int ST_SAFE_BIT = 1;
	localparam int ST_CRCF_BIT = 2;
	// key that services the watchdog and leaves the safe state
	localparam logic [7:0] WDOG_KEY = 8'ha5;
	// watchdog timing
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned WDOG_TIME_NS = 98_300_000;
	localparam int unsigned WDOG_CYCLES = WDOG_TIME_NS / CLK_PERIOD_NS;
	// reset values and crc polynomial
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	localparam logic [7:0] CRC_RST = 8'h00;
	localparam logic [7:0] CRC_POLY = 8'h07;
	// chain word width
	localparam int CW = 16;
endpackage

/* File: hw/dir_top.sv */
// die identity readout: apb registers, watchdog, chain role and forwarding
//
// How it works
// - 0x2f holds column [7:2], row top [1:0]
// - 0x30 holds row bottom [7:4], wafer [3:0]
// - identity fuses never enter trim crc
// - watchdog expiry moves device to safe state
// - role pin selects chain head or member
// - members forward results down; head to spi
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module dir_top #(
	parameter int unsigned WDOG_LIMIT = dir_pkg::WDOG_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// otp fuse contents, static after power-up
	input wire logic [5:0] otp_column,
	input wire logic [1:0] otp_die_row_upper,
	input wire logic [3:0] otp_die_row_lower,
	input wire logic [3:0] otp_wafer,
	input wire logic [31:0] otp_trim,
	input wire logic [7:0] otp_trim_crc,
	// role selection pin
	input wire logic role_pin,
	// local measurement results
	input wire logic meas_valid,
	input wire logic [dir_pkg::CW-1:0] meas_data,
	output logic meas_drop,
	// chain from the device above
	input wire logic up_valid,
	input wire logic [dir_pkg::CW-1:0] up_data,
	// chain toward the head
	output logic down_valid,
	output logic [dir_pkg::CW-1:0] down_data,
	// spi side of the head
	output logic spi_tx_valid,
	output logic [dir_pkg::CW-1:0] spi_tx_data,
	// state
	output logic role_head,
	output logic safe_state
);
	import dir_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// apb decode
	logic [7:0] idx; // word index
	logic access; // access phase not yet answered
	logic done; // edge where master samples pready
	logic wr_done; // write takes effect
	logic [7:0] page_r; // page select
	logic wdog_hit; // valid watchdog service
	logic [31:0] rd_nxt; // read mux
	logic err_nxt; // unmapped or misaligned
	logic [7:0] crc_r; // trim crc
	logic crc_fail_r; // trim crc mismatch
	logic [24:0] wdog_cnt_r; // watchdog count
	logic safe_r; // safe state
	logic role_m_r; // role pin stage one
	logic role_s_r; // role pin stage two

	// the word index drops the byte lane bits; anything outside the
	// 256 word window or off a word boundary is answered with an error
	assign idx = paddr[9:2];
	assign access = psel & penable & ~pready;
	assign done = psel & penable & pready;
	assign wr_done = done & pwrite & ~pslverr;
	assign wdog_hit = wr_done & (idx == WDOG_IDX) & (pwdata[7:0] == WDOG_KEY);

	// read mux; fuse registers show only on the fuse page
	always_comb begin
		rd_nxt = RDATA_RST;
		err_nxt = (paddr[11:10] != 2'b00) | (paddr[1:0] != 2'b00);
		case (idx)
			FUSE_UP_IDX: begin
				if (page_r == PAGE_FUSE) begin
					rd_nxt[COL_LSB +: 6] = otp_column;
					rd_nxt[ROWU_LSB +: 2] = otp_die_row_upper;
				end
			end
			FUSE_LO_IDX: begin
				if (page_r == PAGE_FUSE) begin
					rd_nxt[ROWL_LSB +: 4] = otp_die_row_lower;
					rd_nxt[WAFER_LSB +: 4] = otp_wafer;
				end
			end
			STATUS_IDX: begin
				rd_nxt[ST_ROLE_BIT] = role_head;
				rd_nxt[ST_SAFE_BIT] = safe_r;
				rd_nxt[ST_CRCF_BIT] = crc_fail_r;
			end
			WDOG_IDX: rd_nxt = {7'h00, wdog_cnt_r};
			CRC_IDX: rd_nxt[7:0] = crc_r;
			PAGE_IDX: rd_nxt[7:0] = page_r;
			default: err_nxt = 1'b1;
		endcase
	end

	// one wait state, answer registered, dropped after the sampling edge
	// the access cycle is taken once, then pready stands for one cycle;
	// a master that holds penable past that edge sees pready low again
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RDATA_RST;
		end else if (access) begin
			pready <= 1'b1;
			pslverr <= err_nxt;
			prdata <= pwrite ? RDATA_RST : (err_nxt ? RDATA_RST : rd_nxt);
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// page select, changed only by a write to it
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			page_r <= PAGE_RST;
		end else if (wr_done && idx == PAGE_IDX) begin
			page_r <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// trim crc over trim bits only; identity fuses are not wired in
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = CRC_RST;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			crc_r <= CRC_RST;
			crc_fail_r <= 1'b0;
		end else begin
			crc_r <= crc8(otp_trim);
			crc_fail_r <= (crc_r != otp_trim_crc);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// watchdog; expiry enters safe state, keyed write services and leaves it
	// the counter freezes at the limit so the state cannot wrap back out;
	// a service write in the expiry cycle wins, the host just made it
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wdog_cnt_r <= 25'h000_0000;
			safe_r <= 1'b0;
		end else if (wdog_hit) begin
			wdog_cnt_r <= 25'h000_0000;
			safe_r <= 1'b0;
		end else if (wdog_cnt_r >= 25'(WDOG_LIMIT - 1)) begin
			safe_r <= 1'b1;
		end else begin
			wdog_cnt_r <= wdog_cnt_r + 25'h000_0001;
		end
	end
	assign safe_state = safe_r;

	////////////////////////////////////////////////////////////////////////////
	// role pin synchroniser; stage two drives the role
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			role_m_r <= 1'b0;
			role_s_r <= 1'b0;
		end else begin
			role_m_r <= role_pin;
			role_s_r <= role_m_r;
		end
	end
	assign role_head = role_s_r;

	////////////////////////////////////////////////////////////////////////////
	// chain input synchroniser, two stages
	logic up_v_m_r;
	logic up_v_s_r;
	logic [CW-1:0] up_d_m_r;
	logic [CW-1:0] up_d_s_r;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			up_v_m_r <= 1'b0;
			up_v_s_r <= 1'b0;
			up_d_m_r <= '0;
			up_d_s_r <= '0;
		end else begin
			up_v_m_r <= up_valid;
			up_v_s_r <= up_v_m_r;
			up_d_m_r <= up_data;
			up_d_s_r <= up_d_m_r;
		end
	end

	// forwarding: upstream word wins, local word lost if both arrive
	// no buffer here, so a collision costs the local word and is flagged
	logic fwd_v;
	logic [CW-1:0] fwd_d;
	assign fwd_v = ~safe_r & (up_v_s_r | meas_valid);
	assign fwd_d = up_v_s_r ? up_d_s_r : meas_data;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			down_valid <= 1'b0;
			down_data <= '0;
			spi_tx_valid <= 1'b0;
			spi_tx_data <= '0;
			meas_drop <= 1'b0;
		end else begin
			down_valid <= fwd_v & ~role_s_r;
			spi_tx_valid <= fwd_v & role_s_r;
			down_data <= fwd_d;
			spi_tx_data <= fwd_d;
			meas_drop <= meas_valid & (up_v_s_r | safe_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	fuse_upper_map_a: assert property (access && !pwrite && idx == FUSE_UP_IDX && paddr[11:10] == 2'b00
		&& paddr[1:0] == 2'b00 && page_r == PAGE_FUSE |=> prdata == {24'h00_0000, otp_column, otp_die_row_upper})
		else $error("fuse upper layout wrong");
	fuse_lower_map_a: assert property (access && !pwrite && idx == FUSE_LO_IDX && paddr[11:10] == 2'b00
		&& paddr[1:0] == 2'b00 && page_r == PAGE_FUSE |=> prdata == {24'h00_0000, otp_die_row_lower, otp_wafer})
		else $error("fuse lower layout wrong");
	// the first edge after reset loads the crc, so it is left out here
	crc_excl_a: assert property ($stable(otp_trim) && !$past(sys_rst) |=> $stable(crc_r))
		else $error("crc moved without trim change");
	wdog_expire_a: assert property (!wdog_hit && wdog_cnt_r >= 25'(WDOG_LIMIT - 1) |=> safe_r)
		else $error("watchdog expiry missed");
	safe_quiet_a: assert property (safe_r && !wdog_hit |=> ##1 !down_valid && !spi_tx_valid)
		else $error("chain active in safe state");
	role_follow_a: assert property ($rose(role_pin) ##1 role_pin [*2] |-> role_head)
		else $error("role not taken from pin");
	chain_route_a: assert property (fwd_v |=> ($past(role_head) ? spi_tx_valid && !down_valid
		: down_valid && !spi_tx_valid) && down_data == $past(fwd_d))
		else $error("chain routing wrong");
	page_hold_a: assert property (!(wr_done && idx == PAGE_IDX) |=> $stable(page_r))
		else $error("page changed without write");
	page_read_a: assert property (done && !pwrite && idx != PAGE_IDX |=> $stable(page_r) [*2])
		else $error("read disturbed page");

	// apb answer timing: one edge after the access is taken, one cycle long
	apb_wait_a: assert property (access |=> pready)
		else $error("pready late");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	// a refused transfer returns zero data
	apb_err_zero_a: assert property (pready && pslverr |-> prdata == RDATA_RST)
		else $error("error read not zero");
	// the upper fuse register stays hidden until the fuse page is selected
	fuse_hidden_a: assert property (access && !pwrite && idx == FUSE_UP_IDX && page_r != PAGE_FUSE
		|=> prdata == RDATA_RST)
		else $error("fuse shown off page");
	// service clears count and safe state
	wdog_service_a: assert property (wdog_hit |=> !safe_r && wdog_cnt_r == 25'h000_0000)
		else $error("service ignored");
	// safe state only at the limit, never early
	wdog_early_a: assert property (wdog_cnt_r < 25'(WDOG_LIMIT - 1) && !safe_r |=> !safe_r)
		else $error("safe state too early");
	// a local word in safe state is flagged as lost
	drop_safe_a: assert property (meas_valid && safe_r |=> meas_drop)
		else $error("safe drop not flagged");

	fuse_read_c: cover property (access && !pwrite && idx == FUSE_LO_IDX && page_r == PAGE_FUSE);
	wdog_trip_c: cover property ($rose(safe_r));
	head_fwd_c: cover property (spi_tx_valid ##1 meas_drop);
	page_set_c: cover property (wr_done && idx == PAGE_IDX);
	member_fwd_c: cover property (down_valid);
endmodule // dir_top

/* File: sim/dir_up_model.sv */
// upstream chain neighbour model feeding the block
`timescale 1ns/1ps
module dir_up_model (
	// clock
	input wire logic ref_clk,
	// chain toward the block
	output logic up_valid,
	output logic [15:0] up_data
);
	initial begin
		up_valid = 1'b0;
		up_data = 16'h0000;
	end
	// one word: data steady around a one-cycle valid
	task automatic put(input logic [15:0] w);
		up_data <= w;
		repeat (2) @(posedge ref_clk);
		up_valid <= 1'b1;
		@(posedge ref_clk);
		up_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
		up_data <= ~w; // released line shows the inverse
	endtask
endmodule // dir_up_model

/* File: sim/tb.sv */
// self-checking bench for the die identity readout
`timescale 1ns/1ps
module tb;
	import dir_pkg::*;
	localparam int unsigned LIM = 400;
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, role_pin, meas_valid, meas_drop;
	logic up_valid, down_valid, spi_tx_valid, role_head, safe_state;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, otp_trim;
	logic [5:0] otp_column;
	logic [1:0] rowu;
	logic [3:0] rowl, wafer;
	logic [7:0] tcrc;
	logic [15:0] meas_data, up_data, down_data, spi_tx_data, w;
	int num_errors = 0;
	int n_checks = 0;
	int seed = 32'hcef7;
	int n_drop = 0;
	logic [33:0] bq[$]; // notes {check data, err, data}
	logic [16:0] cq[$]; // notes {head, word}
	logic [33:0] be;
	logic [16:0] ce;
	//////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	dir_top #(.WDOG_LIMIT(LIM)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.otp_column(otp_column), .otp_die_row_upper(rowu), .otp_die_row_lower(rowl), .otp_wafer(wafer),
		.otp_trim(otp_trim), .otp_trim_crc(tcrc), .role_pin(role_pin), .meas_valid(meas_valid),
		.meas_data(meas_data), .meas_drop(meas_drop), .up_valid(up_valid), .up_data(up_data),
		.down_valid(down_valid), .down_data(down_data), .spi_tx_valid(spi_tx_valid),
		.spi_tx_data(spi_tx_data), .role_head(role_head), .safe_state(safe_state));
	dir_up_model up (.ref_clk(ref_clk), .up_valid(up_valid), .up_data(up_data));
	//////////////////////////////////////////////////////////////////////////
	task automatic fail(input string m);
		num_errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) fail(m);
	endtask
	// apb transfer, answer noted first
	task automatic xfer(input logic wr_n, input logic [7:0] i, input logic [31:0] d, input logic [33:0] e);
		int n;
		bq.push_back(e);
		psel <= 1'b1;
		pwrite <= wr_n;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) begin
			fail("no pready");
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		xfer(1'b1, i, {24'h00_0000, d}, {2'b00, 32'h0000_0000});
	endtask
	task automatic rd(input logic [7:0] i, input logic [32:0] e);
		xfer(1'b0, i, 32'h0000_0000, {1'b1, e});
	endtask
	// local word; noted only when it should come out
	task automatic meas(input logic head, input logic exp);
		logic [15:0] d;
		d = $random(seed);
		if (exp) cq.push_back({head, d});
		meas_valid <= 1'b1;
		meas_data <= d;
		@(posedge ref_clk);
		meas_valid <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	task automatic end_sim();
		if (bq.size() != 0 || cq.size() != 0) fail("answers missing");
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////
	// apb answer watcher
	always @(posedge ref_clk) if (pready === 1'b1) begin
		n_checks++;
		if (bq.size() == 0) fail("unexpected pready");
		else begin
			be = bq.pop_front();
			if (pslverr !== be[32] || (be[33] && prdata !== be[31:0])) fail("apb answer");
		end
	end
	// lost local word counter
	always @(posedge ref_clk) if (meas_drop === 1'b1) n_drop++;
	// chain word watcher
	always @(posedge ref_clk) if (down_valid === 1'b1 || spi_tx_valid === 1'b1) begin
		n_checks++;
		if (cq.size() == 0) fail("unexpected chain word");
		else begin
			ce = cq.pop_front();
			if (spi_tx_valid !== ce[16] || down_valid !== !ce[16]) fail("chain path");
			else if ((ce[16] ? spi_tx_data : down_data) !== ce[15:0]) fail("chain data");
		end
	end
	initial begin
		#60000;
		fail("timeout");
		end_sim();
	end
	//////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, role_pin, meas_valid} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		meas_data = 16'h0000;
		{otp_column, rowu, rowl, wafer} = $random(seed);
		otp_trim = $random(seed);
		tcrc = crc8(otp_trim);
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(PAGE_IDX, {25'h0, PAGE_RST});
		rd(FUSE_UP_IDX, 33'h0);
		wr(PAGE_IDX, PAGE_FUSE);
		rd(PAGE_IDX, {25'h0, PAGE_FUSE});
		rd(FUSE_UP_IDX, {25'h0, otp_column, rowu});
		rd(FUSE_LO_IDX, {25'h0, rowl, wafer});
		rd(FUSE_UP_IDX, {25'h0, otp_column, rowu});
		rd(8'h31, {1'b1, 32'h0000_0000});
		$display("test fuses done");
		wr(WDOG_IDX, WDOG_KEY);
		rd(CRC_IDX, {25'h0, crc8(otp_trim)});
		{otp_column, rowu, rowl, wafer} <= ~{otp_column, rowu, rowl, wafer};
		tcrc <= ~tcrc;
		repeat (3) @(posedge ref_clk);
		rd(CRC_IDX, {25'h0, crc8(otp_trim)});
		rd(STATUS_IDX, 33'h4);
		$display("test crc done");
		meas(1'b0, 1'b1);
		w = $random(seed);
		cq.push_back({1'b0, w});
		up.put(w);
		repeat (4) @(posedge ref_clk);
		role_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk(role_head === 1'b1, "role head");
		rd(STATUS_IDX, 33'h5);
		meas(1'b1, 1'b1);
		$display("test chain done");
		wr(WDOG_IDX, WDOG_KEY);
		repeat (LIM - 100) @(posedge ref_clk);
		chk(safe_state === 1'b0, "early safe");
		repeat (200) @(posedge ref_clk);
		chk(safe_state === 1'b1, "no safe state");
		meas(1'b1, 1'b0);
		chk(n_drop == 1, "drop not flagged");
		wr(WDOG_IDX, WDOG_KEY);
		repeat (2) @(posedge ref_clk);
		chk(safe_state === 1'b0, "stuck safe");
		rd(STATUS_IDX, 33'h5);
		$display("test watchdog done");
		end_sim();
	end
endmodule // tb
